//--- src/dmfc_flow_ctrl.sv
`timescale 1ns/1ps
`include "dmfc_regs.svh"
// Summary of operation
// R1: Entry with monitor_select set jumps to vector_base plus 0x01C in monitor mode.
// R2: Entry with monitor_select clear stalls in on-chip-debug mode awaiting dbg_insn_reg.
// R3: halt_session_flag stays set for the whole debug session.
// R4: dbg_return_addr captures the halted address; return goes there unless altered.
// R5: Monitor entry masks other exceptions and interrupts; monitor may unmask.
// R6: dbg_mask_bit set on monitor entry; clearing it re-enables debug entry.
// R7: Debug exception in monitor mode enters on-chip-debug mode regardless.
// R8: dbg_state_flag set while in on-chip-debug mode.
// R9: Write to dbg_insn_reg clears insn_done_flag until done, then halts.
// R10: First instruction in upper half; words form a contiguous halfword stream.
// R11: Debugger pads an upper-half final instruction with a no-operation.
// R12: Breakpoints, watchpoints and trace inactive in on-chip-debug mode.
// R13: Executing the debug-return opcode from dbg_insn_reg leaves on-chip-debug mode.
// R14: Entry only when enabled and unmasked; eight listed causes are valid. Here an abort enters even when disabled or masked.
// R15: Separate cause flags, several may set together.
// R16: Software setting halt_session_flag does not enter debug mode.
// R17: halt_request_bit enters debug before the next instruction executes.
// R18: PC breakpoint halts before the matched instruction executes.
// R19: skip_first_match suppresses only a repeated PC breakpoint on return.
// R20: Data breakpoint enters after the access; return to first unexecuted instruction.
// R21: Breakpoint instruction runs as no-operation when entry disabled.
// R22: Breakpoint instruction triggers before executing; skip_first_match ignored for it.
// R23: Return restores program counter and cpu_status_reg from saved copies.
// R24: Faults in debug mode are silently ignored.
// R25: Cause flags latched at entry, stable throughout the session.
module dmfc_flow_ctrl
   import dmfc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire dmfc_core_t core_in,
   input wire logic ocd_insn_done,
   input wire logic ocd_insn_is_return,
   input wire logic mon_return,
   output logic [31:0] fetch_addr,
   output logic fetch_redirect,
   output logic [31:0] ocd_insn,
   output logic ocd_insn_valid,
   output logic core_stall,
   output logic brk_as_nop,
   output logic fault_suppress,
   output logic bp_trace_enable,
   output logic irq_mask,
   output logic debug_mode
);
   // ==========================================================
   // Registers
   // ==========================================================
   dmfc_state_t state_r;
   logic [31:0] ctrl_r;
   dmfc_cause_t cause_r;
   logic done_r;
   logic [31:0] insn_r;
   logic [31:0] raddr_r;
   logic [31:0] rstat_r;
   logic [31:0] vbase_r;
   logic [31:0] csr_r;
   logic skip_arm_r;
   logic step_arm_r;
   logic [11:0] awaddr_r;
   logic aw_have_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic w_have_r;
   function automatic logic [31:0] dmfc_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return res;
   endfunction : dmfc_merge
   // ==========================================================
   // AXI4-Lite write path
   // ==========================================================
   logic wr_go;
   logic in_debug;
   assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
   assign in_debug = state_r != DMFC_RUN;
   always_ff @(posedge mclk) begin
      if (rst) begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         awaddr_r <= 12'h000;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end else begin
         s_axi_awready <= !aw_have_r && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready <= !w_have_r && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            unique case (awaddr_r)
               `DMFC_CTRL_ADDR, `DMFC_INSN_ADDR, `DMFC_RADDR_ADDR, `DMFC_RSTAT_ADDR, `DMFC_VBASE_ADDR,
               `DMFC_CSR_ADDR, `DMFC_STAT_ADDR: s_axi_bresp <= 2'b00;
               default: s_axi_bresp <= 2'b10;
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   // ==========================================================
   // Entry decision
   // ==========================================================
   logic dbg_enabled;
   logic dbg_masked;
   logic skip_pc;
   dmfc_cause_t hit;
   logic take_entry;
   assign dbg_enabled = ctrl_r[`DMFC_CTL_EN];
   assign dbg_masked = csr_r[`DMFC_SR_DMASK];
   assign skip_pc = skip_arm_r; // R19
   always_comb begin
      hit = '0;
      if (core_in.valid && state_r != DMFC_OCD_FETCH && state_r != DMFC_OCD_WAIT) begin
         hit.request = ctrl_r[`DMFC_CTL_HALT]; // R17
         hit.pc_bp = core_in.pc_bp && !skip_pc; // R18 R19
         hit.data_bp = core_in.data_bp; // R20
         hit.brk_insn = core_in.brk_insn; // R22
         hit.zero_op = core_in.zero_op;
         hit.step = step_arm_r;
         hit.event_pin = core_in.event_pin;
         hit.abort = core_in.abort;
      end
   end
   // Abort ignores enable and mask; everything else needs enable and unmask
   assign take_entry = (dbg_enabled && !dbg_masked && (|hit)) || hit.abort; // R14 R16
   // ==========================================================
   // Mode sequencing
   // ==========================================================
   logic to_monitor;
   logic ocd_exit;
   assign to_monitor = ctrl_r[`DMFC_CTL_MON] && state_r == DMFC_RUN; // R1 R7
   assign ocd_exit = state_r == DMFC_OCD_FETCH && ocd_insn_done && ocd_insn_is_return; // R13
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_r <= DMFC_RUN;
      end else begin
         unique case (state_r)
            DMFC_RUN: begin
               if (take_entry) begin
                  state_r <= to_monitor ? DMFC_MONITOR : DMFC_OCD_WAIT; // R1 R2
               end
            end
            DMFC_MONITOR: begin
               if (take_entry) begin
                  state_r <= DMFC_OCD_WAIT; // R7
               end else if (mon_return) begin
                  state_r <= DMFC_RUN;
               end
            end
            DMFC_OCD_FETCH: begin
               if (ocd_exit) begin
                  state_r <= DMFC_RUN; // R13
               end else if (ocd_insn_done) begin
                  state_r <= DMFC_OCD_WAIT; // R9
               end
            end
            DMFC_OCD_WAIT: begin
               if (wr_go && awaddr_r == `DMFC_INSN_ADDR) begin
                  state_r <= DMFC_OCD_FETCH; // R9
               end
            end
         endcase
      end
   end
   // ==========================================================
   // Control and debug register writes
   // ==========================================================
   logic wr_ctrl;
   assign wr_ctrl = wr_go && awaddr_r == `DMFC_CTRL_ADDR;
   always_ff @(posedge mclk) begin
      if (rst) begin
         ctrl_r <= `DMFC_CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_r <= dmfc_merge(ctrl_r, wdata_r, wstrb_r);
      end else if (take_entry && hit.request) begin
         ctrl_r[`DMFC_CTL_HALT] <= 1'b0; // One request, one entry
      end
   end
   // Skip is armed at the return and spent on the first boundary
   always_ff @(posedge mclk) begin
      if (rst) begin
         skip_arm_r <= 1'b0;
      end else if (ocd_exit || (state_r == DMFC_MONITOR && mon_return)) begin
         skip_arm_r <= ctrl_r[`DMFC_CTL_SKIP]; // R19
      end else if (state_r == DMFC_RUN && core_in.valid) begin
         skip_arm_r <= 1'b0;
      end
   end
   // Step lets one boundary pass after a return and halts on the next one
   always_ff @(posedge mclk) begin
      if (rst) begin
         step_arm_r <= 1'b0;
      end else if (ocd_exit || (state_r == DMFC_MONITOR && mon_return)) begin
         step_arm_r <= 1'b0;
      end else if (state_r == DMFC_RUN && core_in.valid) begin
         step_arm_r <= ctrl_r[`DMFC_CTL_STEP] && !step_arm_r;
      end
   end
   // Cause flags latched at entry only
   always_ff @(posedge mclk) begin
      if (rst) begin
         cause_r <= '0;
      end else if (take_entry) begin
         cause_r <= hit; // R15 R25
      end
   end
   // Instruction word
   always_ff @(posedge mclk) begin
      if (rst) begin
         insn_r <= 32'h00000000;
      end else if (wr_go && awaddr_r == `DMFC_INSN_ADDR) begin
         insn_r <= dmfc_merge(insn_r, wdata_r, wstrb_r); // R10
      end
   end
   // Completion wins over a same-cycle write, since the state also returns to waiting
   always_ff @(posedge mclk) begin
      if (rst) begin
         done_r <= 1'b1;
      end else if (state_r == DMFC_OCD_FETCH && ocd_insn_done) begin
         done_r <= 1'b1; // R9
      end else if (wr_go && awaddr_r == `DMFC_INSN_ADDR) begin
         done_r <= 1'b0; // R9
      end
   end
   // Return address, return status, vector base, core status
   always_ff @(posedge mclk) begin
      if (rst) begin
         raddr_r <= 32'h00000000;
         rstat_r <= 32'h00000000;
         vbase_r <= 32'h00000000;
         csr_r <= `DMFC_CSR_RST;
      end else begin
         if (wr_go && awaddr_r == `DMFC_VBASE_ADDR) begin
            vbase_r <= dmfc_merge(vbase_r, wdata_r, wstrb_r);
         end
         if (take_entry && state_r == DMFC_RUN) begin
            raddr_r <= core_in.pc; // R4 R18 R20
            rstat_r <= csr_r;
            csr_r[`DMFC_SR_HALT] <= 1'b1; // R3
            csr_r[`DMFC_SR_DMASK] <= to_monitor; // R6
            csr_r[`DMFC_SR_IMASK] <= 1'b1; // R5
         end else if (ocd_exit || (state_r == DMFC_MONITOR && mon_return)) begin
            csr_r <= rstat_r; // R23
         end else begin
            if (wr_go && awaddr_r == `DMFC_RADDR_ADDR) begin
               raddr_r <= dmfc_merge(raddr_r, wdata_r, wstrb_r); // R4
            end
            if (wr_go && awaddr_r == `DMFC_RSTAT_ADDR) begin
               rstat_r <= dmfc_merge(rstat_r, wdata_r, wstrb_r);
            end
            if (wr_go && awaddr_r == `DMFC_CSR_ADDR) begin
               csr_r <= dmfc_merge(csr_r, wdata_r, wstrb_r); // R16
            end
         end
      end
   end
   // ==========================================================
   // Core-facing outputs
   // ==========================================================
   always_ff @(posedge mclk) begin
      if (rst) begin
         fetch_addr <= 32'h00000000;
         fetch_redirect <= 1'b0;
         ocd_insn <= 32'h00000000;
         ocd_insn_valid <= 1'b0;
         core_stall <= 1'b0;
         brk_as_nop <= 1'b0;
         fault_suppress <= 1'b0;
         bp_trace_enable <= 1'b1;
         irq_mask <= 1'b0;
         debug_mode <= 1'b0;
      end else begin
         fetch_redirect <= 1'b0;
         if (take_entry && to_monitor) begin
            fetch_addr <= vbase_r + `DMFC_MON_OFFSET; // R1
            fetch_redirect <= 1'b1;
         end else if (ocd_exit || (state_r == DMFC_MONITOR && mon_return)) begin
            fetch_addr <= raddr_r; // R23
            fetch_redirect <= 1'b1;
         end
         ocd_insn <= insn_r;
         ocd_insn_valid <= state_r == DMFC_OCD_FETCH && !ocd_insn_done;
         core_stall <= state_r == DMFC_OCD_WAIT; // R2 R9
         brk_as_nop <= !dbg_enabled || dbg_masked; // R21
         fault_suppress <= in_debug; // R24
         bp_trace_enable <= state_r != DMFC_OCD_WAIT && state_r != DMFC_OCD_FETCH; // R12
         irq_mask <= csr_r[`DMFC_SR_IMASK] && in_debug; // R5
         debug_mode <= csr_r[`DMFC_SR_HALT]; // R3
      end
   end
   // ==========================================================
   // AXI4-Lite read path
   // ==========================================================
   logic [31:0] stat_word;
   always_comb begin
      stat_word = 32'h00000000;
      stat_word[`DMFC_ST_CAUSE_LO +: 8] = cause_r;
      stat_word[`DMFC_ST_DBG] = state_r == DMFC_OCD_WAIT || state_r == DMFC_OCD_FETCH; // R8
      stat_word[`DMFC_ST_DONE] = done_r;
      stat_word[`DMFC_ST_MONITOR] = state_r == DMFC_MONITOR;
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'b00;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            unique case (s_axi_araddr)
               `DMFC_CTRL_ADDR: s_axi_rdata <= ctrl_r;
               `DMFC_STAT_ADDR: s_axi_rdata <= stat_word;
               `DMFC_INSN_ADDR: s_axi_rdata <= insn_r;
               `DMFC_RADDR_ADDR: s_axi_rdata <= raddr_r;
               `DMFC_RSTAT_ADDR: s_axi_rdata <= rstat_r;
               `DMFC_VBASE_ADDR: s_axi_rdata <= vbase_r;
               `DMFC_CSR_ADDR: s_axi_rdata <= csr_r;
               default: begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= 2'b10;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule : dmfc_flow_ctrl

//--- common/dmfc_regs.svh
`ifndef DMFC_REGS_SVH
`define DMFC_REGS_SVH
// Register byte addresses
`define DMFC_CTRL_ADDR 12'h000
`define DMFC_STAT_ADDR 12'h004
`define DMFC_INSN_ADDR 12'h008
`define DMFC_RADDR_ADDR 12'h00c
`define DMFC_RSTAT_ADDR 12'h010
`define DMFC_VBASE_ADDR 12'h014
`define DMFC_CSR_ADDR 12'h018
// Control register fields
`define DMFC_CTL_EN 0
`define DMFC_CTL_MON 1
`define DMFC_CTL_HALT 2
`define DMFC_CTL_SKIP 3
`define DMFC_CTL_STEP 4
// Status register fields
`define DMFC_ST_CAUSE_LO 0
`define DMFC_ST_DBG 8
`define DMFC_ST_DONE 9
`define DMFC_ST_MONITOR 10
// Core status register fields
`define DMFC_SR_HALT 0
`define DMFC_SR_DMASK 1
`define DMFC_SR_IMASK 2
// Monitor vector offset
`define DMFC_MON_OFFSET 32'h0000001c
// Special opcodes
`define DMFC_OP_RETURN 16'hd623
`define DMFC_OP_NOP 16'hd703
`define DMFC_OP_ZERO 16'h0000
// Reset values
`define DMFC_CTRL_RST 32'h00000000
`define DMFC_CSR_RST 32'h00000000
`endif

//--- common/dmfc_pkg.sv
package dmfc_pkg;
   typedef enum logic [1:0] {
      DMFC_RUN = 2'b00,
      DMFC_MONITOR = 2'b01,
      DMFC_OCD_FETCH = 2'b11,
      DMFC_OCD_WAIT = 2'b10
   } dmfc_state_t;
   // Cause bit order in the status register
   typedef struct packed {
      logic abort;
      logic event_pin;
      logic step;
      logic zero_op;
      logic brk_insn;
      logic data_bp;
      logic pc_bp;
      logic request;
   } dmfc_cause_t;
   // Core-side instruction boundary report
   typedef struct packed {
      logic valid;
      logic [31:0] pc;
      logic brk_insn;
      logic zero_op;
      logic pc_bp;
      logic data_bp;
      logic event_pin;
      logic abort;
      logic fault;
   } dmfc_core_t;
endpackage : dmfc_pkg

//--- dv/dmfc_flow_ctrl_monitor.sv
`timescale 1ns/1ps
module dmfc_flow_ctrl_monitor (
   input wire logic mclk,
   input wire logic rst,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic ocd_insn_done,
   input wire logic ocd_insn_is_return,
   input wire logic ocd_insn_valid,
   input wire logic fetch_redirect,
   input wire logic core_stall,
   input wire logic fault_suppress,
   input wire logic bp_trace_enable,
   input wire logic irq_mask,
   input wire logic debug_mode
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   // ==========================
   // Debugger word completion
   sequence s_ocd_step;
      ocd_insn_valid && ocd_insn_done && !ocd_insn_is_return;
   endsequence
   sequence s_ocd_ret;
      ocd_insn_valid && ocd_insn_done && ocd_insn_is_return;
   endsequence
   chk_rst_state: assert property ($fell(rst) |-> !s_axi_bvalid && !s_axi_rvalid && bp_trace_enable && !debug_mode)
      else $error("outputs not idle after reset");
   chk_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   chk_b_single: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   chk_r_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read response repeated");
   chk_redir_pulse: assert property (fetch_redirect |=> !fetch_redirect)
      else $error("redirect longer than one cycle");
   chk_ocd_flags: assert property (core_stall || ocd_insn_valid |-> debug_mode && !bp_trace_enable)
      else $error("ocd mode without session or with breakpoints live");
   chk_insn_halt: assert property (s_ocd_step |-> ##[1:2] core_stall)
      else $error("no halt after debugger word");
   chk_ocd_exit: assert property (s_ocd_ret |-> ##[1:3] !debug_mode)
      else $error("return word did not leave debug mode");
   chk_mon_mask: assert property (fetch_redirect && !debug_mode |=> irq_mask && debug_mode)
      else $error("monitor entered with interrupts open");
   chk_fault_mask: assert property (core_stall || ocd_insn_valid || irq_mask |-> fault_suppress)
      else $error("faults not suppressed in debug mode");
endmodule : dmfc_flow_ctrl_monitor

bind dmfc_flow_ctrl dmfc_flow_ctrl_monitor i_dmfc_flow_ctrl_monitor (.mclk, .rst, .s_axi_awready, .s_axi_wready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .ocd_insn_done, .ocd_insn_is_return,
   .ocd_insn_valid, .fetch_redirect, .core_stall, .fault_suppress, .bp_trace_enable, .irq_mask, .debug_mode);

//--- dv/dmfc_core_model.sv
`timescale 1ns/1ps
`include "dmfc_regs.svh"
module dmfc_core_model
   import dmfc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic slow,
   input wire logic [31:0] ocd_insn,
   input wire logic ocd_insn_valid,
   output logic ocd_insn_done,
   output logic ocd_insn_is_return
);
   logic busy_r;
   logic [2:0] wait_r;
   // ==========================
   // One word executed per grant
   always_ff @(posedge mclk) begin
      if (rst) begin
         busy_r <= 1'b0;
         wait_r <= 3'h0;
         ocd_insn_done <= 1'b0;
         ocd_insn_is_return <= 1'b0;
      end else begin
         ocd_insn_done <= 1'b0;
         // Flag is meaningless outside done, so keep it moving
         ocd_insn_is_return <= ~ocd_insn_is_return;
         if (!ocd_insn_valid) begin
            busy_r <= 1'b0;
         end else if (!busy_r) begin
            if (wait_r >= {slow, 2'b00}) begin
               ocd_insn_done <= 1'b1;
               ocd_insn_is_return <= (ocd_insn[31:16] == `DMFC_OP_RETURN);
               busy_r <= 1'b1;
               wait_r <= 3'h0;
            end else begin
               wait_r <= wait_r + 3'h1;
            end
         end
      end
   end
endmodule : dmfc_core_model

//--- dv/test_debug_mode_flow_control.sv
`timescale 1ns/1ps
`include "dmfc_regs.svh"
module test_debug_mode_flow_control
   import dmfc_pkg::*;
;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic slow_r = 1'b0;
   logic mon_ret_r = 1'b0;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, fetch_addr, ocd_insn, vb, pa, pb;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   dmfc_core_t core_in;
   logic ocd_insn_done, ocd_insn_is_return, fetch_redirect, ocd_insn_valid, core_stall;
   logic brk_as_nop, fault_suppress, bp_trace_enable, irq_mask, debug_mode;
   int err_total = 0;
   int n_checks = 0;
   logic [34:0] notes[$];
   always #10 mclk = ~mclk;
   dmfc_flow_ctrl i_dmfc_flow_ctrl (.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .core_in, .ocd_insn_done, .ocd_insn_is_return, .mon_return(mon_ret_r), .fetch_addr,
      .fetch_redirect, .ocd_insn, .ocd_insn_valid, .core_stall, .brk_as_nop, .fault_suppress,
      .bp_trace_enable, .irq_mask, .debug_mode);
   dmfc_core_model i_dmfc_core_model (.mclk, .rst, .slow(slow_r), .ocd_insn, .ocd_insn_valid,
      .ocd_insn_done, .ocd_insn_is_return);
   // ==========================
   // Helpers
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task wrap_up;
      if (err_total == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : wrap_up
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge mclk);
      notes.push_back({1'b0, er, 32'h0});
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!(s_axi_bvalid && s_axi_bready) && n < 50);
      s_axi_bready <= 1'b0;
      if (n >= 50) err_total++;
   endtask : axi_wr
   task automatic axi_rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge mclk);
      notes.push_back({1'b1, er, exp});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!(s_axi_rvalid && s_axi_rready) && n < 50);
      s_axi_rready <= 1'b0;
      if (n >= 50) err_total++;
   endtask : axi_rd
   // Causes: brk, zero, pc_bp, data_bp, event, abort, fault
   task automatic bnd(input logic [31:0] pc, input logic [6:0] c);
      @(posedge mclk);
      core_in <= {1'b1, pc, c};
      @(posedge mclk);
      core_in <= {1'b0, ~pc, ~c};
   endtask : bnd
   task automatic wait_redir(input logic [31:0] exp);
      int n;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (fetch_redirect !== 1'b1 && n < 20);
      check({31'h0, fetch_redirect}, 32'h1);
      check(fetch_addr, exp);
   endtask : wait_redir
   always @(posedge mclk) begin
      logic [34:0] nt;
      if (!rst && ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready))) begin
         nt = notes.pop_front();
         check({30'h0, nt[34] ? s_axi_rresp : s_axi_bresp}, {30'h0, nt[33:32]});
         if (nt[34]) check(s_axi_rdata, nt[31:0]);
      end
   end
   initial begin
      #400us;
      err_total++;
      wrap_up();
   end
   // ==========================
   // Main sequence
   initial begin
      void'($urandom(86406));
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_awaddr = '0;
      s_axi_araddr = '0;
      s_axi_wdata = '0;
      core_in = '0;
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      vb = $urandom() & 32'hffff_fff0;
      pa = $urandom() & 32'h00ff_fffe;
      pb = pa + 32'h4;
      axi_rd(`DMFC_CTRL_ADDR, `DMFC_CTRL_RST, 2'b00);
      axi_rd(`DMFC_CSR_ADDR, `DMFC_CSR_RST, 2'b00);
      axi_rd(12'hffc, 32'h0, 2'b10);
      axi_wr(12'hffc, 32'h5a5a_a5a5, 2'b10);
      bnd(pa, 7'h40);
      repeat (6) @(posedge mclk);
      check({31'h0, debug_mode}, 32'h0);
      check({31'h0, brk_as_nop}, 32'h1);
      axi_wr(`DMFC_CTRL_ADDR, 32'h1, 2'b00);
      axi_wr(`DMFC_CSR_ADDR, 32'h1, 2'b00);
      repeat (6) @(posedge mclk);
      check({30'h0, core_stall, bp_trace_enable}, 32'h1);
      axi_wr(`DMFC_CSR_ADDR, 32'h0, 2'b00);
      axi_wr(`DMFC_CTRL_ADDR, 32'h5, 2'b00);
      bnd(pa, 7'h18);
      repeat (6) @(posedge mclk);
      check({29'h0, core_stall, debug_mode, bp_trace_enable}, 32'h6);
      axi_wr(`DMFC_INSN_ADDR, {`DMFC_OP_NOP, `DMFC_OP_NOP}, 2'b00);
      repeat (8) @(posedge mclk);
      axi_rd(`DMFC_STAT_ADDR, 32'h0000_0307, 2'b00);
      axi_rd(`DMFC_RADDR_ADDR, pa, 2'b00);
      axi_wr(`DMFC_CTRL_ADDR, 32'h9, 2'b00);
      slow_r <= 1'b1;
      axi_wr(`DMFC_INSN_ADDR, {`DMFC_OP_RETURN, `DMFC_OP_NOP}, 2'b00);
      wait_redir(pa);
      bnd(pa, 7'h10);
      repeat (6) @(posedge mclk);
      check({31'h0, core_stall}, 32'h0);
      bnd(pb, 7'h48);
      repeat (6) @(posedge mclk);
      check({31'h0, core_stall}, 32'h1);
      axi_rd(`DMFC_RADDR_ADDR, pb, 2'b00);
      axi_wr(`DMFC_INSN_ADDR, {`DMFC_OP_RETURN, `DMFC_OP_NOP}, 2'b00);
      wait_redir(pb);
      axi_wr(`DMFC_VBASE_ADDR, vb, 2'b00);
      axi_wr(`DMFC_CTRL_ADDR, 32'h3, 2'b00);
      bnd(pa, 7'h40);
      wait_redir(vb + `DMFC_MON_OFFSET);
      @(posedge mclk);
      check({30'h0, irq_mask, core_stall}, 32'h2);
      axi_rd(`DMFC_CSR_ADDR, 32'h7, 2'b00);
      bnd(pb, 7'h10);
      repeat (6) @(posedge mclk);
      check({31'h0, core_stall}, 32'h0);
      axi_wr(`DMFC_CSR_ADDR, 32'h5, 2'b00);
      bnd(pb, 7'h10);
      repeat (6) @(posedge mclk);
      check({31'h0, core_stall}, 32'h1);
      axi_wr(`DMFC_CTRL_ADDR, 32'h11, 2'b00);
      axi_wr(`DMFC_INSN_ADDR, {`DMFC_OP_RETURN, `DMFC_OP_NOP}, 2'b00);
      wait_redir(pa);
      bnd(pa, 7'h00);
      repeat (6) @(posedge mclk);
      check({31'h0, core_stall}, 32'h0);
      bnd(pb, 7'h00);
      repeat (6) @(posedge mclk);
      axi_rd(`DMFC_STAT_ADDR, 32'h0000_0320, 2'b00);
      axi_rd(`DMFC_RADDR_ADDR, pb, 2'b00);
      axi_wr(`DMFC_CTRL_ADDR, 32'h3, 2'b00);
      axi_wr(`DMFC_INSN_ADDR, {`DMFC_OP_RETURN, `DMFC_OP_NOP}, 2'b00);
      wait_redir(pb);
      bnd(pa, 7'h40);
      wait_redir(vb + `DMFC_MON_OFFSET);
      mon_ret_r <= 1'b1;
      @(posedge mclk);
      mon_ret_r <= 1'b0;
      wait_redir(pa);
      axi_rd(`DMFC_CSR_ADDR, 32'h0, 2'b00);
      wrap_up();
   end
endmodule : test_debug_mode_flow_control
